// File: design/xpc_ctrl.sv
// Purpose: Drives the crosspoint latch programming pins from commands.
// Assumes: Device pins sampled synchronously to ref_clk at 10 MHz.
// Notes:   One command at a time; results return on the rsp port.
`timescale 1ns/1ns
`include "xpc_defs.svh"
module xpc_ctrl (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire xpc_pkg::xpc_op_t cmd_op,
    input wire logic [4:0] cmd_addr,
    input wire logic [6:0] cmd_data,
    // Response port
    output logic rsp_valid,
    output logic rsp_err,
    output logic [6:0] rsp_data,
    // Device control pins, all active low, then the address pins
    output logic xp_cs_n,
    output logic xp_we_n,
    output logic second_rank_rd_n,
    output logic xp_update_n,
    output logic xp_reset_n,
    output logic [4:0] xp_addr,
    // Two-way data bus
    input wire logic [6:0] xp_d_i,
    output logic [6:0] xp_d_o,
    output logic xp_d_oe
);
    import xpc_pkg::*;

    // ============================================================
    // Declarations
    // ============================================================
    xpc_state_t state_q;   // Sequencer state.
    xpc_op_t op_q;         // Command being carried out.
    logic cs_n_q;          // Chip select pin.
    logic we_n_q;          // First rank write pin.
    logic rd_n_q;          // Readback pin.
    logic upd_n_q;         // Update pin.
    logic rst_n_q;         // Global output disable pin.
    logic [4:0] addr_q;    // Address pins.
    logic [6:0] dout_q;    // Data driven onto the bus.
    logic doe_q;           // Bus drive enable.
    logic rsp_valid_q;     // Response strobe.
    logic rsp_err_q;       // Response refused flag.
    logic [6:0] rsp_data_q; // Captured readback word.
    logic accept;          // Command offered while idle; taken only when ce is high.
    logic addr_bad;        // Output code is reserved.
    logic data_bad;        // Input code is reserved.
    logic cmd_bad;         // Command must be refused.
    logic is_write;        // Command drives the bus.
    logic [6:0] wdata;     // Word to place on the bus.

    xpc_tmr_if tmr_if ();

    xpc_tmr u_tmr (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ce(ce),
        .tmr(tmr_if.tmr)
    );

    // ============================================================
    // Command checks
    // ============================================================
    // Output codes above 16 other than broadcast are refused for reads and writes.
    assign addr_bad = (cmd_addr > `XPC_MAX_OUT)
                      && (cmd_addr != `XPC_BCAST);
    // An input code only matters when the enable bit is set.
    assign data_bad = cmd_data[`XPC_EN_BIT]
                      && (cmd_data[5:0] > `XPC_MAX_IN);
    assign is_write = (cmd_op == XPC_OP_WRITE)
                      || (cmd_op == XPC_OP_WRUPD);
    // Broadcast has no readback word, so such a read is refused.
    assign cmd_bad = (cmd_op == XPC_OP_READ)
                     ? (addr_bad || (cmd_addr == `XPC_BCAST))
                     : (is_write && (addr_bad || data_bad));
    // A disable write sends zeros in the select field.
    assign wdata = cmd_data[`XPC_EN_BIT] ? cmd_data
                   : {1'b0, 6'h00};
    assign accept = cmd_valid && (state_q == XPC_ST_IDLE);
    assign cmd_ready = (state_q == XPC_ST_IDLE);

    // ============================================================
    // Timer requests
    // ============================================================
    // Strobe widths are loaded on entry to the strobe, hold on exit.
    always_comb
    begin
        tmr_if.load = 1'b0;
        tmr_if.count = 8'h00;
        case (state_q)
            XPC_ST_IDLE:
            begin
                if (ce && accept && !cmd_bad && cmd_op == XPC_OP_RESET)
                begin
                    tmr_if.load = 1'b1;
                    tmr_if.count = 8'(`XPC_CYC_TW);
                end
                else if (ce && accept && !cmd_bad)
                begin
                    tmr_if.load = 1'b1;
                    tmr_if.count = 8'(`XPC_CYC_DSW);
                end
            end
            XPC_ST_SETUP:
            begin
                if (tmr_if.done)
                begin
                    tmr_if.load = 1'b1;
                    case (op_q)
                        XPC_OP_READ: tmr_if.count = 8'(`XPC_CYC_RD);
                        XPC_OP_WRITE: tmr_if.count = 8'(`XPC_CYC_WP);
                        default: tmr_if.count = 8'(`XPC_CYC_UW);
                    endcase
                end
            end
            XPC_ST_STROBE:
            begin
                if (tmr_if.done)
                begin
                    tmr_if.load = 1'b1;
                    tmr_if.count = 8'(`XPC_CYC_WHU);
                end
            end
            default:
            begin
                tmr_if.load = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Sequencer
    // ============================================================
    // Every pin is a flip-flop so the device never sees glitches.
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_q <= XPC_ST_IDLE;
            op_q <= XPC_OP_WRITE;
            cs_n_q <= `XPC_PIN_IDLE;
            we_n_q <= `XPC_PIN_IDLE;
            rd_n_q <= `XPC_PIN_IDLE;
            upd_n_q <= `XPC_PIN_IDLE;
            rst_n_q <= `XPC_PIN_IDLE;
            addr_q <= 5'h00;
            dout_q <= 7'h00;
            doe_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_err_q <= 1'b0;
            rsp_data_q <= 7'h00;
        end
        else if (ce)
        begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                XPC_ST_IDLE:
                begin
                    if (accept && cmd_bad)
                    begin
                        // Refused: no pin moves, error answer only.
                        rsp_valid_q <= 1'b1;
                        rsp_err_q <= 1'b1;
                    end
                    else if (accept && cmd_op == XPC_OP_RESET)
                    begin
                        // Reset needs no chip select.
                        op_q <= cmd_op;
                        rst_n_q <= `XPC_PIN_ACT;
                        state_q <= XPC_ST_RST;
                    end
                    else if (accept)
                    begin
                        // Select the chip and set address and data.
                        op_q <= cmd_op;
                        cs_n_q <= `XPC_PIN_ACT;
                        addr_q <= cmd_addr;
                        dout_q <= wdata;
                        doe_q <= is_write;
                        state_q <= XPC_ST_SETUP;
                    end
                end
                XPC_ST_SETUP:
                begin
                    if (tmr_if.done)
                    begin
                        // Pull the strobes that this command needs.
                        case (op_q)
                            XPC_OP_WRITE:
                                we_n_q <= `XPC_PIN_ACT;
                            XPC_OP_UPDATE:
                                upd_n_q <= `XPC_PIN_ACT;
                            XPC_OP_WRUPD:
                            begin
                                // Both low: word goes straight through.
                                we_n_q <= `XPC_PIN_ACT;
                                upd_n_q <= `XPC_PIN_ACT;
                            end
                            XPC_OP_READ:
                                rd_n_q <= `XPC_PIN_ACT;
                            default:
                                we_n_q <= `XPC_PIN_IDLE;
                        endcase
                        state_q <= XPC_ST_STROBE;
                    end
                end
                XPC_ST_STROBE:
                begin
                    if (tmr_if.done)
                    begin
                        // Data are sampled before readback is released.
                        if (op_q == XPC_OP_READ)
                            rsp_data_q <= xp_d_i;
                        we_n_q <= `XPC_PIN_IDLE;
                        rd_n_q <= `XPC_PIN_IDLE;
                        upd_n_q <= `XPC_PIN_IDLE;
                        state_q <= XPC_ST_HOLD;
                    end
                end
                XPC_ST_HOLD:
                begin
                    if (tmr_if.done)
                    begin
                        // Deselect only after the strobes are back high.
                        cs_n_q <= `XPC_PIN_IDLE;
                        doe_q <= 1'b0;
                        rsp_valid_q <= 1'b1;
                        rsp_err_q <= 1'b0;
                        state_q <= XPC_ST_IDLE;
                    end
                end
                XPC_ST_RST:
                begin
                    if (tmr_if.done)
                    begin
                        rst_n_q <= `XPC_PIN_IDLE;
                        rsp_valid_q <= 1'b1;
                        rsp_err_q <= 1'b0;
                        state_q <= XPC_ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= XPC_ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    // The bus is never driven during readback, which avoids fighting
    // the device's weak readback drivers.
    assign xp_cs_n = cs_n_q;
    assign xp_we_n = we_n_q;
    assign second_rank_rd_n = rd_n_q;
    assign xp_update_n = upd_n_q;
    assign xp_reset_n = rst_n_q;
    assign xp_addr = addr_q;
    assign xp_d_o = dout_q;
    assign xp_d_oe = doe_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_err = rsp_err_q;
    assign rsp_data = rsp_data_q;
endmodule

// File: design/xpc_defs.svh
// Purpose: Constants for the crosspoint latch programming controller.
// Assumes: Clock ref_clk at 10 MHz; all times below are in nanoseconds.
// Notes:   Cycle counts are least times, rounded up, never below one.
//
// What this block does
// - Enable write routes output to selected input
// - Broadcast output address code is 10001
// - Never read back at broadcast address
// - Never use reserved output or input codes; an update is not checked and puts any output code on the address pins
`ifndef XPC_DEFS_SVH
`define XPC_DEFS_SVH

// ============================================================
// Address and data layout
// ============================================================
`define XPC_ADDR_W 5
`define XPC_DATA_W 7
`define XPC_SEL_W 6
`define XPC_EN_BIT 6
`define XPC_MAX_OUT 5'h10
`define XPC_BCAST 5'h11
`define XPC_MAX_IN 6'h20

// ============================================================
// Pin idle levels (all control pins are active low)
// ============================================================
`define XPC_PIN_IDLE 1'b1
`define XPC_PIN_ACT 1'b0

// ============================================================
// Timing
// ============================================================
`define XPC_CLK_NS 100
`define XPC_T_WP_NS 15
`define XPC_T_UW_NS 15
`define XPC_T_WHU_NS 10
`define XPC_T_RD_NS 30
`define XPC_T_TW_NS 15
`define XPC_T_DSW_NS 15
`define XPC_NS2CYC(t) \
    ((((t) + `XPC_CLK_NS - 1) / `XPC_CLK_NS) < 1 ? 1 : \
    (((t) + `XPC_CLK_NS - 1) / `XPC_CLK_NS))
`define XPC_CYC_WP `XPC_NS2CYC(`XPC_T_WP_NS)
`define XPC_CYC_UW `XPC_NS2CYC(`XPC_T_UW_NS)
`define XPC_CYC_WHU `XPC_NS2CYC(`XPC_T_WHU_NS)
`define XPC_CYC_RD `XPC_NS2CYC(`XPC_T_RD_NS)
`define XPC_CYC_TW `XPC_NS2CYC(`XPC_T_TW_NS)
`define XPC_CYC_DSW `XPC_NS2CYC(`XPC_T_DSW_NS)

`endif

// File: design/xpc_pkg.sv
// Purpose: Types shared by the crosspoint controller files.
// Assumes: Nothing beyond the constants header.
// Notes:   Numbers live in xpc_defs.svh; only types are here.
package xpc_pkg;

    // ============================================================
    // Commands accepted on the user port
    // ============================================================
    typedef enum logic [2:0] {
        XPC_OP_WRITE = 3'b000,  // Load one first-rank word, or all of them at broadcast.
        XPC_OP_UPDATE = 3'b001, // Copy first rank to second rank.
        XPC_OP_WRUPD = 3'b010,  // Write straight through to second rank.
        XPC_OP_READ = 3'b011,   // Read back one second-rank word.
        XPC_OP_RESET = 3'b100   // Pulse the global output disable pin.
    } xpc_op_t;

    // ============================================================
    // Sequencer states
    // ============================================================
    typedef enum logic [2:0] {
        XPC_ST_IDLE = 3'b000,
        XPC_ST_SETUP = 3'b001,
        XPC_ST_STROBE = 3'b010,
        XPC_ST_HOLD = 3'b011,
        XPC_ST_RST = 3'b100
    } xpc_state_t;

endpackage

// File: design/xpc_tmr.sv
// Purpose: Down counter that times strobe widths and setup gaps.
// Assumes: Synchronous active-low reset, clock enable freezes it.
// Notes:   A load of N raises done N cycles later, for one cycle.
`timescale 1ns/1ns
module xpc_tmr (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // Count request
    xpc_tmr_if.tmr tmr
);
    import xpc_pkg::*;

    logic [7:0] cnt_q; // Remaining cycles, zero when idle.
    logic [7:0] cnt_d; // Next value of the count.

    // ============================================================
    // Count logic
    // ============================================================
    // Load wins over decrement so a back-to-back request is not lost.
    assign cnt_d = tmr.load ? tmr.count :
                   (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
    // Done looks at the count alone. The sequencer raises load from
    // done, so gating done by load would close a combinational loop.
    assign tmr.done = (cnt_q == 8'h01);

    // Count register, frozen while ce is low.
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            cnt_q <= 8'h00;
        else if (ce)
            cnt_q <= cnt_d;
    end
endmodule

// File: design/xpc_tmr_if.sv
// Purpose: Carries a cycle count request and its done flag.
// Assumes: One clock domain shared by both ends.
// Notes:   done is combinational in the timer.
`timescale 1ns/1ns
interface xpc_tmr_if;
    logic load;        // Start a new count this cycle.
    logic [7:0] count; // Number of cycles until done.
    logic done;        // High in the last counted cycle.

    modport ctrl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// File: verification/crosspoint_config_latches_tb.sv
// Purpose: Self-checking bench for the crosspoint latch controller.
// Assumes: 10 MHz clock; a reference model of both ranks in integers.
// Notes:   Clock enable is randomly dropped to stretch some transfers.
`timescale 1ns/1ns
`include "xpc_defs.svh"
module crosspoint_config_latches_tb;
    import xpc_pkg::*;
    logic ref_clk = 1'b0;
    logic ce = 1'b1; // Driven only by the enable process below.
    logic resetn, cmd_valid, cmd_ready, rsp_valid, rsp_err;
    logic xp_cs_n, xp_we_n, second_rank_rd_n, xp_update_n, xp_reset_n;
    logic xp_d_oe, dev_oe;
    xpc_op_t cmd_op;
    logic [4:0] cmd_addr, xp_addr;
    logic [6:0] cmd_data, rsp_data, xp_d_o, dev_d, bus;
    integer seed = 74139;
    integer bad_count = 0;
    integer check_count = 0;
    integer cyc = 0;
    int e1 [17]; // Expected first rank.
    int e2 [17]; // Expected second rank.
    // The bus carries whoever drives it.
    assign bus = xp_d_oe ? xp_d_o : dev_d;
    always #50 ref_clk = ~ref_clk;
    // Enable drops one cycle in eight, but never during reset.
    always @(posedge ref_clk)
        ce <= !resetn || ($random(seed) & 7) != 0;
    xpc_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_err(rsp_err), .rsp_data(rsp_data), .xp_cs_n(xp_cs_n),
        .xp_we_n(xp_we_n), .second_rank_rd_n(second_rank_rd_n),
        .xp_update_n(xp_update_n), .xp_reset_n(xp_reset_n),
        .xp_addr(xp_addr), .xp_d_i(bus), .xp_d_o(xp_d_o),
        .xp_d_oe(xp_d_oe));
    xpc_dev_model i_dev (.cs_n(xp_cs_n), .we_n(xp_we_n),
        .rd_n(second_rank_rd_n), .upd_n(xp_update_n), .rst_n(xp_reset_n),
        .addr(xp_addr), .d_i(bus), .d_o(dev_d), .d_oe(dev_oe));
    // ============================================================
    // Compare and closing tasks
    // ============================================================
    task automatic check_err(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t refusal %b not %b", $time, got, exp);
        end
    endtask
    task automatic check_data(input logic [6:0] got, input logic [6:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t read %h not %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // A hang counts as a mismatch.
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            $display("CHECK FAILED %0t run did not finish", $time);
            results();
        end
    end
    // ============================================================
    // One command: offer, wait for take and answer, check, model
    // ============================================================
    task automatic run(input xpc_op_t op, input logic [4:0] a,
        input logic [6:0] d);
        logic err;
        int n;
        err = (op == XPC_OP_READ) ? a > 5'h10 :
            (op == XPC_OP_WRITE || op == XPC_OP_WRUPD) &&
            (a > 5'h11 || (d[6] && d[5:0] > 6'h20));
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        n = 0;
        do @(posedge ref_clk); while (!(ce && cmd_ready) && ++n < 50);
        cmd_valid <= 1'b0;
        do @(posedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 100);
        // A command that is never answered must not pass on stale data.
        if (rsp_valid !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED %0t command not answered", $time);
        end
        check_err(rsp_err, err);
        if (op == XPC_OP_READ && !err)
            check_data(rsp_data, 7'(e2[a]));
        for (int i = 0; i < 17; i++)
            if (!err && op != XPC_OP_READ)
            begin
                if (op != XPC_OP_UPDATE && op != XPC_OP_RESET &&
                    (a == 5'h11 || a == 5'(i)))
                    e1[i] = d[6] ? d : 0;
                if (op == XPC_OP_UPDATE || op == XPC_OP_WRUPD)
                    e2[i] = e1[i];
                if (op == XPC_OP_RESET)
                    e2[i] = e2[i] & 'h3f;
            end
    endtask
    task automatic read_all;
        for (int i = 0; i < 17; i++)
            run(XPC_OP_READ, 5'(i), 7'h00);
    endtask
    function automatic logic [6:0] rnd_word();
        return {1'($random(seed)), 6'(($random(seed) & 'hffff) % 33)};
    endfunction
    // Refused commands: reserved addresses, reserved input, bad reads.
    xpc_op_t bad_op [5] = '{XPC_OP_WRITE, XPC_OP_WRITE, XPC_OP_WRUPD,
        XPC_OP_READ, XPC_OP_READ};
    logic [4:0] bad_a [5] = '{5'h12, 5'h1f, 5'h03, 5'h11, 5'h14};
    logic [6:0] bad_d [5] = '{7'h47, 7'h47, 7'h61, 7'h00, 7'h00};
    initial
    begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = XPC_OP_WRITE;
        cmd_addr = 5'h00;
        cmd_data = 7'h00;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        run(XPC_OP_WRITE, `XPC_BCAST, 7'h47);
        run(XPC_OP_UPDATE, 5'h00, 7'h00);
        read_all();
        for (int i = 0; i < 17; i++)
            run(XPC_OP_WRITE, 5'(i), rnd_word());
        run(XPC_OP_READ, 5'h10, 7'h00);
        run(XPC_OP_UPDATE, 5'h00, 7'h00);
        read_all();
        run(XPC_OP_WRUPD, `XPC_MAX_OUT, 7'h60);
        run(XPC_OP_READ, `XPC_MAX_OUT, 7'h00);
        run(XPC_OP_WRITE, 5'h05, 7'h05);
        run(XPC_OP_UPDATE, 5'h00, 7'h00);
        run(XPC_OP_READ, 5'h05, 7'h00);
        for (int i = 0; i < 5; i++)
            run(bad_op[i], bad_a[i], bad_d[i]);
        run(XPC_OP_READ, 5'h03, 7'h00);
        run(XPC_OP_RESET, 5'h00, 7'h00);
        read_all();
        run(XPC_OP_UPDATE, 5'h00, 7'h00);
        read_all();
        repeat (60)
            run(xpc_op_t'(($random(seed) & 'hff) % 5),
                5'(($random(seed) & 'hff) % 18), rnd_word());
        read_all();
        results();
    end
endmodule

// File: verification/xpc_ctrl_sva.sv
// Purpose: Pin protocol checks on the crosspoint latch controller.
// Assumes: One clock; resetn is synchronous and active low.
// Notes:   Sees only the top ports; the bind sits after the module.
`timescale 1ns/1ns
module xpc_ctrl_sva (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // Command and response
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire xpc_pkg::xpc_op_t cmd_op,
    input wire logic [4:0] cmd_addr,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    // Device pins
    input wire logic xp_cs_n,
    input wire logic xp_we_n,
    input wire logic second_rank_rd_n,
    input wire logic xp_update_n,
    input wire logic xp_reset_n,
    input wire logic [4:0] xp_addr,
    input wire logic [6:0] xp_d_o,
    input wire logic xp_d_oe
);
    import xpc_pkg::*;
    // ============================================================
    // Assertions
    // ============================================================
    // Everything here lives in the one clock domain.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Strobes outside chip select would be ignored by the device.
    strobe_in_cs_a: assert property (xp_cs_n |->
        xp_we_n && second_rank_rd_n && xp_update_n)
        else $error("strobe active without chip select");
    // Driving the bus during readback would fight the device.
    drive_in_cs_a: assert property (xp_d_oe |->
        !xp_cs_n && second_rank_rd_n) else $error("bus driven badly");
    // Data and address must settle a cycle before the write strobe.
    write_setup_a: assert property ($fell(xp_we_n) |-> !xp_cs_n &&
        xp_d_oe && $stable(xp_d_o) && $stable(xp_addr))
        else $error("write strobe without setup");
    write_addr_a: assert property (!xp_we_n |->
        xp_addr <= 5'h10 || xp_addr == 5'h11)
        else $error("write to reserved address");
    write_input_a: assert property (!xp_we_n && xp_d_o[6] |->
        xp_d_o[5:0] <= 6'h20) else $error("reserved input code");
    disable_zero_a: assert property (!xp_we_n && !xp_d_o[6] |->
        xp_d_o == 7'h00) else $error("disable word not zero");
    read_addr_a: assert property (!second_rank_rd_n |->
        xp_addr <= 5'h10) else $error("readback at bad address");
    // A refused readback must leave chip select and readback high for two cycles.
    read_refuse_a: assert property (cmd_valid && cmd_ready && ce &&
        cmd_op == XPC_OP_READ && cmd_addr > 5'h10 |=>
        (xp_cs_n && second_rank_rd_n)[*2])
        else $error("refused readback moved pins");
    reset_done_a: assert property ($rose(xp_reset_n) |->
        rsp_valid && !rsp_err) else $error("reset pulse unanswered");
    pass_through_a: assert property (!xp_update_n && !xp_we_n |->
        !xp_cs_n && xp_d_oe) else $error("pass through without data");
    // Main scenarios.
    bcast_c: cover property (!xp_we_n && xp_addr == 5'h11);
    read_c: cover property (!second_rank_rd_n);
    wrupd_c: cover property (!xp_we_n && !xp_update_n);
    reset_c: cover property (!xp_reset_n);
endmodule
bind xpc_ctrl xpc_ctrl_sva i_sva (.*);

// File: verification/xpc_dev_model.sv
// Purpose: Behavioural double-rank latch bank seen by the controller.
// Assumes: Pins active low, level sensitive, no clock.
// Notes:   A released bus shows the inverse of the last driven word.
`timescale 1ns/1ns
module xpc_dev_model (
    // Control pins, active low
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic rd_n,
    input wire logic upd_n,
    input wire logic rst_n,
    // Address and data bus
    input wire logic [4:0] addr,
    input wire logic [6:0] d_i,
    output logic [6:0] d_o,
    output logic d_oe
);
    logic [6:0] r1 [17]; // First rank, power-up undefined.
    logic [6:0] r2 [17]; // Second rank, the live connections.
    // Arbitrary start for the released bus.
    initial
    begin
        d_o = 7'h2a;
        d_oe = 1'b0;
    end
    // ============================================================
    // Latches: plain level logic, re-evaluated on any pin change.
    // ============================================================
    always @(cs_n or we_n or rd_n or upd_n or rst_n or addr or d_i)
    begin
        for (int i = 0; i < 17; i++)
        begin
            if (!cs_n && !we_n && (addr == 5'h11 || addr == 5'(i)))
                r1[i] = d_i;
            if (!cs_n && !upd_n)
                r2[i] = r1[i];
            // Reset wins over update and ignores chip select.
            if (!rst_n)
                r2[i][6] = 1'b0;
        end
        if (!cs_n && !rd_n && addr <= 5'h10)
        begin
            d_o = r2[addr];
            d_oe = 1'b1;
        end
        else
        begin
            // Release: the stale word must not linger on the bus.
            if (d_oe)
                d_o = ~d_o;
            d_oe = 1'b0;
        end
    end
endmodule
